// *** flr_pkg.sv ***
`default_nettype none
package flr_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] REG_DC_LIMIT = 8'h03; // Input current limit control
   localparam logic [7:0] REG_LOW_BATT = 8'h04; // Low battery detection control
   localparam logic [7:0] REG_LED1_TORCH = 8'h08; // led1_torch_current
   localparam logic [7:0] REG_LED2_FLASH = 8'h09; // led2_flash_current
   localparam logic [7:0] REG_LED2_MASK = 8'h0a; // led2_transmit_mask_input_current
   localparam logic [7:0] REG_LED2_TORCH = 8'h0b; // led2_torch_current
   localparam logic [7:0] REG_FAULT = 8'h0c; // fault_status
   localparam logic [7:0] REG_SNAPSHOT = 8'h0d; // led1_flash_fault_readback

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_DC_LIMIT = 8'h08; // 2.0A level, limit disabled
   localparam logic [7:0] RST_LOW_BATT = 8'h18; // 5ms window, detection off
   localparam logic [7:0] RST_TORCH = 8'h04; // Torch code 0 0100
   localparam logic [7:0] RST_FLASH = 8'h28; // Flash code 10 1000
   localparam logic [7:0] RST_MASK = 8'h28; // Mask code 10 1000
   localparam logic [7:0] RST_FAULT = 8'h00; // No faults
   localparam logic [7:0] RST_SNAPSHOT = 8'h00; // Empty snapshot
   localparam logic [7:0] RD_UNMAPPED = 8'h00; // Answer for unknown offsets

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int TORCH_W = 5; // Torch code width, bits 4..0
   localparam int FLASH_W = 6; // Flash and mask code width, bits 5..0
   localparam int BIT_OVP = 7;
   localparam int BIT_SHORT = 6;
   localparam int BIT_OTEMP = 5;
   localparam int BIT_TIMEOUT = 4;
   localparam int BIT_MASK_EVT = 3;
   localparam int BIT_LOW_BATT = 2;
   localparam int BIT_IND_LIM = 1;
   localparam int BIT_DC_LIM = 0;
   localparam int DC_EN_BIT = 0; // Limit enable bit in REG_DC_LIMIT
   localparam int LB_SEL_W = 3; // Threshold select, bits 2..0 of REG_LOW_BATT

   // ************************************************************
   // Current scaling, in tenths of a milliamp
   // ************************************************************
   localparam int CUR_W = 14; // Enough for 1122.0mA
   localparam logic [CUR_W-1:0] CUR_STEP = 14'h00bb; // 18.7mA per code
   localparam logic [CUR_W-1:0] TORCH_CAP = 14'h0bb0; // 299.2mA ceiling
   localparam logic [CUR_W-1:0] FLASH_CAP = 14'h2bd4; // 1122mA ceiling

   // ************************************************************
   // Carriers
   // ************************************************************
   // Raw fault indications from the analog side
   typedef struct packed {
      logic ovp;
      logic short_circ;
      logic overtemp;
      logic timeout;
      logic mask_in;
      logic low_batt;
      logic ind_lim;
      logic dc_lim;
   } flr_fault_t;

   // One register write from the serial engine
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } flr_wr_t;

   // Serial engine states
   typedef enum logic [2:0] {
      SER_IDLE, SER_ADDR, SER_REG, SER_WR, SER_ACK, SER_RD, SER_RACK
   } flr_ser_t;

endpackage
`default_nettype wire

// *** flr_code_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
// Turns a current code into tenths of a milliamp, clamped to a ceiling
module flr_code_decode #(
   parameter int CODE_W = 6,
   parameter logic [flr_pkg::CUR_W-1:0] CAP = flr_pkg::FLASH_CAP
) (
   // Code in
   input wire logic [CODE_W-1:0] code,
   // Current out
   output logic [flr_pkg::CUR_W-1:0] current
);

   // Full product, wide enough for the largest code
   logic [flr_pkg::CUR_W+CODE_W-1:0] prod;

   // ************************************************************
   // Scale and clamp
   // ************************************************************
   // Clamping keeps the top codes on the ceiling instead of wrapping
   always_comb begin
      prod = code * flr_pkg::CUR_STEP;
      if (prod > {{CODE_W{1'b0}}, CAP}) begin
         current = CAP;
      end else begin
         current = prod[flr_pkg::CUR_W-1:0];
      end
   end

endmodule
`default_nettype wire

// *** flr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module flr_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h30 // Arbitrary bus address
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Two-wire control pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Fault indications and flash context
   input wire flr_pkg::flr_fault_t fault_in,
   input wire logic flash_active,
   input wire logic [flr_pkg::FLASH_W-1:0] led1_flash_code,
   // Settings to the analog side
   output logic [flr_pkg::TORCH_W-1:0] led1_torch_code,
   output logic [flr_pkg::TORCH_W-1:0] led2_torch_code,
   output logic [flr_pkg::FLASH_W-1:0] led2_flash_code,
   output logic [flr_pkg::FLASH_W-1:0] led2_mask_code,
   output logic dc_limit_enable,
   output logic [flr_pkg::LB_SEL_W-1:0] low_battery_threshold_sel,
   // Decoded currents: 0 torch1, 1 flash2, 2 mask2, 3 torch2
   output logic [3:0][flr_pkg::CUR_W-1:0] led_current,
   // Status views
   output logic [7:0] fault_status,
   output logic [flr_pkg::FLASH_W-1:0] led1_flash_snapshot
);

   // ************************************************************
   // Storage
   // ************************************************************
   logic [7:0] dc_limit_r; // Input current limit control
   logic [7:0] low_batt_r; // Low battery control
   logic [7:0] led1_torch_r; // LED1 torch byte
   logic [7:0] led2_flash_r; // LED2 flash byte
   logic [7:0] led2_mask_r; // LED2 mask byte
   logic [7:0] led2_torch_r; // LED2 torch byte
   logic [7:0] fault_r; // Fault status byte
   logic [7:0] snapshot_r; // Snapshot byte
   logic [3:0][flr_pkg::CUR_W-1:0] cur_r; // Registered currents
   logic [3:0][flr_pkg::CUR_W-1:0] cur_nxt; // Decoder results
   flr_pkg::flr_wr_t wr; // Write from serial engine
   logic fault_rd; // Pulse: fault byte loaded for a read

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [9:0] sync1_r; // First stage, read only by second
   logic [9:0] sync2_r; // Second stage
   logic scl_d_r; // Previous clock level
   logic sda_d_r; // Previous data level
   flr_pkg::flr_fault_t flt; // Synchronised faults
   logic scl_s;
   logic sda_s;

   // Two flops on the bus pins and fault inputs before use; flash_active and led1_flash_code are used directly
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 10'h300; // Pins idle high, faults idle low
         sync2_r <= 10'h300; // No false fault right after reset
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         sync1_r <= {scl_in, sda_in, fault_in};
         sync2_r <= sync1_r;
         scl_d_r <= sync2_r[9];
         sda_d_r <= sync2_r[8];
      end
   end

   assign scl_s = sync2_r[9];
   assign sda_s = sync2_r[8];
   assign flt = sync2_r[7:0];

   // Bus events seen on the synchronised pins
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // ************************************************************
   // Read decode
   // ************************************************************
   // Unknown offsets answer zero rather than stale data
   function automatic logic [7:0] read_byte(input logic [7:0] a);
      case (a)
         flr_pkg::REG_DC_LIMIT: read_byte = dc_limit_r;
         flr_pkg::REG_LOW_BATT: read_byte = low_batt_r;
         flr_pkg::REG_LED1_TORCH: read_byte = led1_torch_r;
         flr_pkg::REG_LED2_FLASH: read_byte = led2_flash_r;
         flr_pkg::REG_LED2_MASK: read_byte = led2_mask_r;
         flr_pkg::REG_LED2_TORCH: read_byte = led2_torch_r;
         flr_pkg::REG_FAULT: read_byte = fault_r;
         flr_pkg::REG_SNAPSHOT: read_byte = snapshot_r;
         default: read_byte = flr_pkg::RD_UNMAPPED;
      endcase
   endfunction

   // ************************************************************
   // Serial engine
   // ************************************************************
   flr_pkg::flr_ser_t st_r; // Engine state
   flr_pkg::flr_ser_t after_ack_r; // State after our acknowledge
   logic [3:0] bit_cnt_r; // Bits moved in current byte
   logic [7:0] sh_r; // Receive shifter
   logic [7:0] tx_r; // Transmit shifter
   logic [7:0] ptr_r; // Register pointer, auto-increments
   logic [7:0] rd_byte; // Byte the pointer addresses
   assign rd_byte = read_byte(ptr_r);

   // Byte transfer with auto-incrementing pointer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= flr_pkg::SER_IDLE;
         after_ack_r <= flr_pkg::SER_IDLE;
         bit_cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_r <= 8'h00;
         sda_oe <= 1'b0;
         wr <= '0;
         fault_rd <= 1'b0;
      end else begin
         wr.en <= 1'b0;
         fault_rd <= 1'b0;
         if (bus_start) begin
            // Start or repeated start restarts addressing
            st_r <= flr_pkg::SER_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            st_r <= flr_pkg::SER_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (st_r)
               flr_pkg::SER_ADDR, flr_pkg::SER_REG, flr_pkg::SER_WR: begin
                  if (scl_rise && bit_cnt_r != 4'h8) begin
                     sh_r <= {sh_r[6:0], sda_s};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (scl_fall && bit_cnt_r == 4'h8) begin
                     sda_oe <= 1'b1;
                     st_r <= flr_pkg::SER_ACK;
                     if (st_r == flr_pkg::SER_ADDR) begin
                        if (sh_r[7:1] != DEV_ADDR) begin
                           // Not for us: stay off the bus
                           sda_oe <= 1'b0;
                           st_r <= flr_pkg::SER_IDLE;
                        end else if (sh_r[0]) begin
                           after_ack_r <= flr_pkg::SER_RD;
                        end else begin
                           after_ack_r <= flr_pkg::SER_REG;
                        end
                     end else if (st_r == flr_pkg::SER_REG) begin
                        ptr_r <= sh_r;
                        after_ack_r <= flr_pkg::SER_WR;
                     end else begin
                        wr.en <= 1'b1;
                        wr.addr <= ptr_r;
                        wr.data <= sh_r;
                        ptr_r <= ptr_r + 8'h01;
                        after_ack_r <= flr_pkg::SER_WR;
                     end
                  end
               end
               flr_pkg::SER_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_r <= 4'h0;
                     st_r <= after_ack_r;
                     sda_oe <= 1'b0;
                     if (after_ack_r == flr_pkg::SER_RD) begin
                        // Load and present first bit of the read byte
                        tx_r <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        fault_rd <= (ptr_r == flr_pkg::REG_FAULT);
                        ptr_r <= ptr_r + 8'h01;
                     end
                  end
               end
               flr_pkg::SER_RD: begin
                  if (scl_fall) begin
                     if (bit_cnt_r == 4'h7) begin
                        sda_oe <= 1'b0;
                        st_r <= flr_pkg::SER_RACK;
                     end else begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        sda_oe <= ~tx_r[6];
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               flr_pkg::SER_RACK: begin
                  // Host ack seen on the rise, so the ack fall presents the next byte
                  if (scl_rise) begin
                     after_ack_r <= flr_pkg::SER_RD;
                     st_r <= sda_s ? flr_pkg::SER_IDLE : flr_pkg::SER_ACK;
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain: only ever pull low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // ************************************************************
   // Writable registers
   // ************************************************************
   // Fault and snapshot offsets have no case here, so writes drop
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dc_limit_r <= flr_pkg::RST_DC_LIMIT;
         low_batt_r <= flr_pkg::RST_LOW_BATT;
         led1_torch_r <= flr_pkg::RST_TORCH;
         led2_flash_r <= flr_pkg::RST_FLASH;
         led2_mask_r <= flr_pkg::RST_MASK;
         led2_torch_r <= flr_pkg::RST_TORCH;
      end else if (wr.en) begin
         case (wr.addr)
            flr_pkg::REG_DC_LIMIT: dc_limit_r <= wr.data;
            flr_pkg::REG_LOW_BATT: low_batt_r <= wr.data;
            flr_pkg::REG_LED1_TORCH: led1_torch_r <= wr.data;
            flr_pkg::REG_LED2_FLASH: led2_flash_r <= wr.data;
            flr_pkg::REG_LED2_MASK: led2_mask_r <= wr.data;
            flr_pkg::REG_LED2_TORCH: led2_torch_r <= wr.data;
            default: dc_limit_r <= dc_limit_r;
         endcase
      end
   end

   // Control fields steering the analog side
   logic dc_en;
   logic lb_en;
   assign dc_en = dc_limit_r[flr_pkg::DC_EN_BIT];
   assign lb_en = |low_batt_r[flr_pkg::LB_SEL_W-1:0];

   // ************************************************************
   // Fault status
   // ************************************************************
   logic flash_d_r; // Previous flash level
   logic dc_d_r; // Previous gated DC limit level
   logic flash_start;
   logic dc_hit;
   assign flash_start = flash_active & ~flash_d_r;
   assign dc_hit = dc_en & flt.dc_lim & ~dc_d_r;

   // Sticky faults, all but the mask and low battery flags, clear when the byte is read; a new fault wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fault_r <= flr_pkg::RST_FAULT;
         flash_d_r <= 1'b0;
         dc_d_r <= 1'b0;
      end else begin
         flash_d_r <= flash_active;
         dc_d_r <= dc_en & flt.dc_lim;
         fault_r[flr_pkg::BIT_OVP] <= flt.ovp | (fault_r[flr_pkg::BIT_OVP] & ~fault_rd);
         fault_r[flr_pkg::BIT_SHORT] <= flt.short_circ
            | (fault_r[flr_pkg::BIT_SHORT] & ~fault_rd);
         fault_r[flr_pkg::BIT_OTEMP] <= flt.overtemp
            | (fault_r[flr_pkg::BIT_OTEMP] & ~fault_rd);
         fault_r[flr_pkg::BIT_TIMEOUT] <= flt.timeout
            | (fault_r[flr_pkg::BIT_TIMEOUT] & ~fault_rd);
         // Mask flag tracks the latest flash only
         if (flash_active && flt.mask_in) begin
            fault_r[flr_pkg::BIT_MASK_EVT] <= 1'b1;
         end else if (flash_start) begin
            fault_r[flr_pkg::BIT_MASK_EVT] <= 1'b0;
         end
         // Live comparison, forced low while detection is off
         fault_r[flr_pkg::BIT_LOW_BATT] <= lb_en & flt.low_batt;
         fault_r[flr_pkg::BIT_IND_LIM] <= flt.ind_lim
            | (fault_r[flr_pkg::BIT_IND_LIM] & ~fault_rd);
         fault_r[flr_pkg::BIT_DC_LIM] <= (dc_en & flt.dc_lim)
            | (fault_r[flr_pkg::BIT_DC_LIM] & ~fault_rd);
      end
   end

   // Snapshot of LED1 flash code on each new DC limit hit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         snapshot_r <= flr_pkg::RST_SNAPSHOT;
      end else if (dc_hit) begin
         snapshot_r <= {2'b00, led1_flash_code};
      end
   end

   // ************************************************************
   // Current decode, one decoder per channel
   // ************************************************************
   logic [3:0][flr_pkg::FLASH_W-1:0] chan_code;
   assign chan_code[0] = {1'b0, led1_torch_r[flr_pkg::TORCH_W-1:0]};
   assign chan_code[1] = led2_flash_r[flr_pkg::FLASH_W-1:0];
   assign chan_code[2] = led2_mask_r[flr_pkg::FLASH_W-1:0];
   assign chan_code[3] = {1'b0, led2_torch_r[flr_pkg::TORCH_W-1:0]};

   // Torch channels share the lower ceiling
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_dec
         flr_code_decode #(
            .CODE_W(flr_pkg::FLASH_W),
            .CAP((gi == 0 || gi == 3) ? flr_pkg::TORCH_CAP : flr_pkg::FLASH_CAP)
         ) u_dec (
            .code(chan_code[gi]),
            .current(cur_nxt[gi])
         );
      end
   endgenerate

   // Register the decoded currents
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cur_r <= '0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // ************************************************************
   // Outputs, all straight from flops
   // ************************************************************
   assign led1_torch_code = led1_torch_r[flr_pkg::TORCH_W-1:0];
   assign led2_torch_code = led2_torch_r[flr_pkg::TORCH_W-1:0];
   assign led2_flash_code = led2_flash_r[flr_pkg::FLASH_W-1:0];
   assign led2_mask_code = led2_mask_r[flr_pkg::FLASH_W-1:0];
   assign dc_limit_enable = dc_limit_r[flr_pkg::DC_EN_BIT];
   assign low_battery_threshold_sel = low_batt_r[flr_pkg::LB_SEL_W-1:0];
   assign led_current = cur_r;
   assign fault_status = fault_r;
   assign led1_flash_snapshot = snapshot_r[flr_pkg::FLASH_W-1:0];

endmodule
`default_nettype wire

// *** flr_regs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches the register bank ports only
module flr_regs_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Two-wire pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Faults and flash context
   input wire flr_pkg::flr_fault_t fault_in,
   input wire logic flash_active,
   input wire logic [5:0] led1_flash_code,
   // Settings and status views
   input wire logic [4:0] led1_torch_code,
   input wire logic [4:0] led2_torch_code,
   input wire logic [5:0] led2_flash_code,
   input wire logic [5:0] led2_mask_code,
   input wire logic dc_limit_enable,
   input wire logic [2:0] low_battery_threshold_sel,
   input wire logic [3:0][13:0] led_current,
   input wire logic [7:0] fault_status,
   input wire logic [5:0] led1_flash_snapshot
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Code times 18.7mA in tenths, clamped to the ceiling
   function automatic logic [13:0] dec(input logic [5:0] c, input logic [13:0] m);
      return (c * 14'd187 > m) ? m : c * 14'd187;
   endfunction
   // Fault held long enough to pass the two sync flops
   sequence s_ovp_held;
      fault_in.ovp [*5];
   endsequence
   sequence s_ind_held;
      fault_in.ind_lim [*5];
   endsequence
   sequence s_masked;
      (fault_in.mask_in && flash_active) [*5];
   endsequence
   sequence s_dc_hit;
      dc_limit_enable && $rose(fault_in.dc_lim);
   endsequence
   // Currents are 0 in the first cycle out of reset, hence the guard
   property p_torch1;
      $past(rst_n) |-> led_current[0] == dec({1'b0, $past(led1_torch_code)}, 14'd2992);
   endproperty
   property p_flash2;
      $past(rst_n) |-> led_current[1] == dec($past(led2_flash_code), 14'd11220);
   endproperty
   property p_lb_off;
      $past(low_battery_threshold_sel) == 3'h0 |-> !fault_status[2];
   endproperty
   property p_dc_gate;
      $rose(fault_status[0]) |-> $past(dc_limit_enable);
   endproperty
   property p_ovp;
      s_ovp_held |-> fault_status[7];
   endproperty
   property p_ind;
      s_ind_held |-> fault_status[1];
   endproperty
   property p_mask;
      s_masked |-> fault_status[3];
   endproperty
   property p_snap;
      s_dc_hit |-> ##[3:6] (led1_flash_snapshot == led1_flash_code);
   endproperty
   // Snapshot may only move while the limit function is on
   property p_snap_hold;
      !dc_limit_enable && !$past(dc_limit_enable) && !$past(dc_limit_enable, 2)
         |-> $stable(led1_flash_snapshot);
   endproperty
   a_torch1: assert property (p_torch1) else $error("torch current wrong");
   a_flash2: assert property (p_flash2) else $error("flash current wrong");
   a_lb_off: assert property (p_lb_off) else $error("low battery bit while off");
   a_dc_gate: assert property (p_dc_gate) else $error("dc bit while disabled");
   a_ovp: assert property (p_ovp) else $error("overvoltage not flagged");
   a_ind: assert property (p_ind) else $error("inductor limit not flagged");
   a_mask: assert property (p_mask) else $error("mask event not flagged");
   a_snap: assert property (p_snap) else $error("snapshot not taken");
   a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");
endmodule
bind flr_regs flr_regs_chk u_chk (.mclk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
   .fault_in, .flash_active, .led1_flash_code, .led1_torch_code, .led2_torch_code,
   .led2_flash_code, .led2_mask_code, .dc_limit_enable, .low_battery_threshold_sel,
   .led_current, .fault_status, .led1_flash_snapshot);
`default_nettype wire

// *** flr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host bus controller; each bus phase is many mclk long
module flr_host #(
   parameter logic [6:0] ADDR = 7'h30 // Device address, arbitrary
) (
   // Clock and sensed wire
   input wire logic mclk,
   input wire logic sda_w,
   // Clock line and pull-down
   output logic scl,
   output logic sda_lo
);
   initial begin
      scl = 1'b1;
      sda_lo = 1'b0;
   end
   // Waits, changes only at falling mclk
   task automatic q(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // One bit; device output settles 3 mclk after SCL fall
   task automatic bitx(input logic b, output logic r);
      q(4);
      sda_lo = !b;
      q(4);
      scl = 1'b1;
      q(6);
      r = sda_w;
      scl = 1'b0;
   endtask
   // Start or repeated start
   task automatic start();
      q(4);
      sda_lo = 1'b0;
      q(4);
      scl = 1'b1;
      q(6);
      sda_lo = 1'b1;
      q(6);
      scl = 1'b0;
   endtask
   task automatic stop();
      q(4);
      sda_lo = 1'b1;
      q(4);
      scl = 1'b1;
      q(6);
      sda_lo = 1'b0;
      q(6);
   endtask
   // Byte MSB first, then the ninth bit
   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r,
      output logic a);
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(ai, a);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      xfer({ADDR, 1'b0}, 1'b1, r, a0);
      xfer(p, 1'b1, r, a1);
      xfer(d, 1'b1, r, a2);
      stop();
      ok = !(a0 | a1 | a2);
   endtask
   // Read ends with a host NACK
   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      start();
      xfer({ADDR, 1'b0}, 1'b1, r, a0);
      xfer(p, 1'b1, r, a1);
      start();
      xfer({ADDR, 1'b1}, 1'b1, r, a2);
      xfer(8'hff, 1'b1, d, a3);
      stop();
      ok = !(a0 | a1 | a2) && a3;
   endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic scl, sda_lo, sda_oe, sda_out, dc_en;
   wire logic sda_w;
   flr_pkg::flr_fault_t fi = '0;
   logic fa = 1'b0;
   logic [5:0] fc = 6'h00;
   logic [4:0] t1, t2;
   logic [5:0] f2, m2, snap;
   logic [2:0] lb;
   logic [3:0][13:0] cur;
   logic [7:0] fst;
   int fails = 0;
   int checks = 0;
   always #10 mclk = ~mclk;
   // Pulled-up wire, low when either side pulls
   assign sda_w = !((sda_oe & !sda_out) | sda_lo);
   flr_regs u_flr_regs (.mclk, .rst_n, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe,
      .fault_in(fi), .flash_active(fa), .led1_flash_code(fc), .led1_torch_code(t1),
      .led2_torch_code(t2), .led2_flash_code(f2), .led2_mask_code(m2),
      .dc_limit_enable(dc_en), .low_battery_threshold_sel(lb), .led_current(cur),
      .fault_status(fst), .led1_flash_snapshot(snap));
   flr_host u_flr_host (.mclk, .sda_w, .scl, .sda_lo);
   // ****************
   // Helpers
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      u_flr_host.wr(a, d, ok);
      chk(16'(ok), 16'h0001);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic ok;
      logic [7:0] d;
      u_flr_host.rd(a, d, ok);
      chk({7'h00, ok, d}, {8'h01, e});
   endtask
   // Code times 187 tenths of a mA, clamped
   function automatic logic [15:0] lim(input logic [5:0] c, input logic [15:0] m);
      return (c * 16'd187 > m) ? m : c * 16'd187;
   endfunction
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      chk(16'(cur[0]), 16'd748);
      chk(16'(cur[1]), 16'd7480);
      chk(16'(cur[2]), 16'd7480);
      chk({12'h0, dc_en, lb}, 16'h0000);
      rd(8'h08, 8'h04);
      rd(8'h09, 8'h28);
      rd(8'h0a, 8'h28);
      rd(8'h0b, 8'h04);
      rd(8'h0c, 8'h00);
      rd(8'h0d, 8'h00);
      rd(8'h20, 8'h00); // Unmapped offset reads zero
   endtask
   task automatic t_torch();
      logic [4:0] c [4] = '{5'h00, 5'h08, 5'h18, 5'h1f};
      foreach (c[i]) begin
         wr(8'h08, {3'h0, c[i]});
         wr(8'h0b, {3'h0, c[i]});
         chk({6'h0, t1, t2}, {6'h0, c[i], c[i]});
         chk(16'(cur[0]), lim({1'b0, c[i]}, 16'd2992));
         chk(16'(cur[3]), lim({1'b0, c[i]}, 16'd2992));
      end
   endtask
   task automatic t_flash();
      logic [5:0] c [5] = '{6'h00, 6'h01, 6'h28, 6'h3c, 6'h3f};
      foreach (c[i]) begin
         wr(8'h09, {2'h0, c[i]});
         wr(8'h0a, {2'h0, c[i]});
         chk({4'h0, f2, m2}, {4'h0, c[i], c[i]});
         chk(16'(cur[1]), lim(c[i], 16'd11220));
         chk(16'(cur[2]), lim(c[i], 16'd11220));
      end
      rd(8'h0a, 8'h3f);
   endtask
   // Sticky faults; dc bit stays off while the limit is disabled
   task automatic t_fault();
      fi = 8'hf3;
      cyc(8);
      fi = '0;
      cyc(8);
      chk(16'(fst), 16'h00f2);
      rd(8'h0c, 8'hf2);
      rd(8'h0c, 8'h00);
      wr(8'h0c, 8'hff);
      rd(8'h0c, 8'h00);
   endtask
   task automatic t_lowbatt();
      wr(8'h04, 8'h19);
      chk(16'(lb), 16'h0001);
      fi.low_batt = 1'b1;
      cyc(6);
      chk(16'(fst), 16'h0004);
      fi.low_batt = 1'b0;
      cyc(6);
      chk(16'(fst), 16'h0000);
      fi.low_batt = 1'b1;
      wr(8'h04, 8'h18);
      chk(16'(fst), 16'h0000);
      fi.low_batt = 1'b0;
   endtask
   task automatic t_dc();
      fc = 6'h2a;
      fi.dc_lim = 1'b1;
      cyc(8);
      chk(16'(fst), 16'h0000);
      fi.dc_lim = 1'b0;
      rd(8'h0d, 8'h00);
      wr(8'h03, 8'h09);
      chk(16'(dc_en), 16'h0001);
      fi.dc_lim = 1'b1;
      cyc(8);
      chk(16'(snap), 16'h002a);
      fc = 6'h15;
      fi.dc_lim = 1'b0;
      rd(8'h0d, 8'h2a);
      wr(8'h0d, 8'h00);
      rd(8'h0d, 8'h2a);
      rd(8'h0c, 8'h01);
      wr(8'h03, 8'h08);
   endtask
   // Mask during a flash, then a clean flash clears the mark
   task automatic t_mask();
      fa = 1'b1;
      fi.mask_in = 1'b1;
      cyc(6);
      fi.mask_in = 1'b0;
      fa = 1'b0;
      cyc(4);
      rd(8'h0c, 8'h08);
      fa = 1'b1;
      cyc(4);
      fa = 1'b0;
      chk(16'(fst), 16'h0000);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      cyc(3);
      rst_n = 1'b1;
      cyc(4);
      t_reset();
      t_torch();
      t_flash();
      t_fault();
      t_lowbatt();
      t_dc();
      t_mask();
      tally_and_finish();
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
